// [rtl/dcd_pkg.sv]
// Package for the spread-spectrum receive demodulator
package dcd_pkg;
  localparam int SW = 8;
  localparam logic [7:0] ROT_REG = 8'h01;
  localparam logic [7:0] LCK_REG = 8'h06;
  localparam logic [7:0] EQ_REG = 8'h0A;
  localparam logic [7:0] TRK_REG = 8'h21;
  localparam logic [7:0] STAT_REG = 8'h40;
  localparam logic [7:0] SEED_REG = 8'h41;
  localparam int ROT_REV_A = 7;
  localparam int ROT_REV_B = 6;
  localparam int EQ_ICI_OFF = 4;
  localparam int EQ_ISI_OFF = 5;
  localparam int LCK_BIT = 2;
  localparam int TRK_SLAVE = 6;
  localparam int BARKER_LEN = 11;
  localparam logic [10:0] BARKER = 11'h0_5B8;
  localparam int CCK_CHIPS = 8;
  localparam int AVG_SYMS = 10;
  localparam int SCR_LEN = 7;
  localparam int SCR_TAP_A = 3;
  localparam int SCR_TAP_B = 6;
  localparam int SEED_SYMS = 7;
  localparam int TIM_STEPS = 8;
  localparam int TIM_LIMIT = 72;
  localparam int LL_SHIFT = 4;
  localparam logic [7:0] RESET_VAL = 8'h00;
  typedef enum logic [1:0] {DCD_R1, DCD_R2, DCD_R55, DCD_R11} dcd_rate_t;
  typedef struct packed {
    logic [SW-1:0] i;
    logic [SW-1:0] q;
  } dcd_iq_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dcd_bus_t;
endpackage : dcd_pkg

// [rtl/dcd_demod.sv]
// Receive demodulator: correlators, decoders, equalizer, tracking, descrambler
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module dcd_demod #(
  parameter int SW = dcd_pkg::SW
) (
  input wire logic clk,
  input wire logic rstn,
  input wire dcd_pkg::dcd_iq_t samp,
  input wire logic samp_valid,
  input wire logic [1:0] rate,
  input wire logic acq_done,
  input wire logic hdr_last,
  input wire logic pkt_end,
  input wire logic service_locked,
  input wire logic train_valid,
  input wire logic signed [SW-1:0] train_ici,
  input wire logic signed [SW-1:0] train_isi,
  input wire dcd_pkg::dcd_bus_t bus,
  output logic [7:0] rdata,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic signed [7:0] timing_pos
);
  localparam int CW = SW + 5;
  logic [7:0] rot_ctrl, eq_ctrl, lck_cfg, trk_ctrl;
  logic rot_rev, slave_on;
  assign rot_rev = rot_ctrl[dcd_pkg::ROT_REV_A] | rot_ctrl[dcd_pkg::ROT_REV_B];
  assign slave_on = trk_ctrl[dcd_pkg::TRK_SLAVE] & lck_cfg[dcd_pkg::LCK_BIT]
                    & service_locked;

  // Register writes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rot_ctrl <= dcd_pkg::RESET_VAL;
      eq_ctrl <= dcd_pkg::RESET_VAL;
      lck_cfg <= dcd_pkg::RESET_VAL;
      trk_ctrl <= dcd_pkg::RESET_VAL;
    end else if (bus.wr) begin
      case (bus.addr)
        dcd_pkg::ROT_REG: rot_ctrl <= bus.wdata;
        dcd_pkg::EQ_REG: eq_ctrl <= bus.wdata;
        dcd_pkg::LCK_REG: lck_cfg <= bus.wdata;
        dcd_pkg::TRK_REG: trk_ctrl <= bus.wdata;
        default: ;
      endcase
    end
  end

  // Derotation by oscillator phase quadrant, then chip phase select
  logic [15:0] nco_ph;
  logic signed [15:0] nco_frq;
  dcd_pkg::dcd_iq_t drot;
  always_comb begin
    case (nco_ph[15:14])
      2'd0: drot = samp;
      2'd1: drot = '{i: samp.q, q: -samp.i};
      2'd2: drot = '{i: -samp.i, q: -samp.q};
      default: drot = '{i: -samp.q, q: samp.i};
    endcase
  end

  // Sample phase within chip, slipped by the interpolator
  logic [3:0] sub;
  logic slip_fwd, slip_bwd;
  logic chip_stb;
  always_ff @(posedge clk) begin
    if (!rstn) sub <= '0;
    else if (samp_valid) sub <= sub + (slip_fwd ? 4'd10 : slip_bwd ? 4'd6 : 4'd8);
  end
  assign chip_stb = samp_valid && sub[3];

  // Chip delay lines, one sample per chip kept
  logic signed [SW-1:0] ci [dcd_pkg::BARKER_LEN];
  logic signed [SW-1:0] cq [dcd_pkg::BARKER_LEN];
  logic signed [SW-1:0] early_i, late_i, early_q, late_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int k = 0; k < dcd_pkg::BARKER_LEN; k++) begin
        ci[k] <= '0;
        cq[k] <= '0;
      end
      early_i <= '0;
      late_i <= '0;
      early_q <= '0;
      late_q <= '0;
    end else if (samp_valid) begin
      if (chip_stb) begin
        ci[0] <= drot.i;
        cq[0] <= drot.q;
        for (int k = 1; k < dcd_pkg::BARKER_LEN; k++) begin
          ci[k] <= ci[k-1];
          cq[k] <= cq[k-1];
        end
      end else begin
        early_i <= late_i;
        early_q <= late_q;
        late_i <= drot.i;
        late_q <= drot.q;
      end
    end
  end

  // Barker correlation, identical code on I and Q
  logic signed [CW-1:0] bi, bq;
  always_comb begin
    bi = '0;
    bq = '0;
    for (int k = 0; k < dcd_pkg::BARKER_LEN; k++) begin
      bi = dcd_pkg::BARKER[k] ? bi + CW'(ci[k]) : bi - CW'(ci[k]);
      bq = dcd_pkg::BARKER[k] ? bq + CW'(cq[k]) : bq - CW'(cq[k]);
    end
  end

  // Symbol chip counter
  logic [3:0] chip_cnt;
  logic sym_stb, cck;
  logic [3:0] sym_len;
  assign cck = rate[1];
  assign sym_len = cck ? 4'(dcd_pkg::CCK_CHIPS) : 4'(dcd_pkg::BARKER_LEN);
  always_ff @(posedge clk) begin
    if (!rstn || acq_done) chip_cnt <= '0;
    else if (chip_stb) chip_cnt <= (chip_cnt == sym_len - 4'd1) ? 4'd0 : chip_cnt + 4'd1;
  end
  assign sym_stb = chip_stb && (chip_cnt == sym_len - 4'd1);

  // Equalizer training, frozen for the packet
  logic trained;
  logic signed [SW-1:0] ici_c, isi_c, isi_res;
  always_ff @(posedge clk) begin
    if (!rstn || pkt_end) begin
      trained <= 1'b0;
      ici_c <= '0;
      isi_c <= '0;
    end else if (train_valid && !trained) begin
      ici_c <= train_ici;
      isi_c <= train_isi;
      trained <= 1'b1;
    end
  end

  // Walsh inputs with ICI and ISI correction
  logic signed [CW-1:0] wi [dcd_pkg::CCK_CHIPS];
  logic signed [CW-1:0] wq [dcd_pkg::CCK_CHIPS];
  always_comb begin
    for (int k = 0; k < dcd_pkg::CCK_CHIPS; k++) begin
      wi[k] = CW'(ci[7-k]);
      wq[k] = CW'(cq[7-k]);
      if (!eq_ctrl[dcd_pkg::EQ_ICI_OFF] && k > 0) begin
        wi[k] = wi[k] - CW'((ici_c * ci[8-k]) >>> (SW - 1));
        wq[k] = wq[k] - CW'((ici_c * cq[8-k]) >>> (SW - 1));
      end
    end
    if (!eq_ctrl[dcd_pkg::EQ_ISI_OFF]) begin
      wi[0] = wi[0] - CW'(isi_res);
    end
    for (int s = 1; s < dcd_pkg::CCK_CHIPS; s = s * 2) begin
      for (int k = 0; k < dcd_pkg::CCK_CHIPS; k++) begin
        if ((k & s) == 0) begin
          {wi[k], wi[k+s]} = {wi[k] + wi[k+s], wi[k] - wi[k+s]};
          {wq[k], wq[k+s]} = {wq[k] + wq[k+s], wq[k] - wq[k+s]};
        end
      end
    end
  end

  // Biggest picker over 4 or 64 candidates
  logic [2:0] pi, pq;
  logic [CW-1:0] mi, mq;
  logic signed [CW-1:0] ai, aq;
  always_comb begin
    pi = '0;
    pq = '0;
    mi = '0;
    mq = '0;
    ai = wi[0];
    aq = wq[0];
    for (int k = 0; k < dcd_pkg::CCK_CHIPS; k++) begin
      if (rate == 2'(dcd_pkg::DCD_R11) || k < 2) begin
        if ((wi[k][CW-1] ? -wi[k] : wi[k]) > mi) begin
          mi = wi[k][CW-1] ? -wi[k] : wi[k];
          pi = 3'(k);
          ai = wi[k];
        end
        if ((wq[k][CW-1] ? -wq[k] : wq[k]) > mq) begin
          mq = wq[k][CW-1] ? -wq[k] : wq[k];
          pq = 3'(k);
          aq = wq[k];
        end
      end
    end
  end

  // Symbol phase quadrant and differential decode
  logic signed [CW-1:0] di, dq;
  logic [1:0] quad, prev_quad, dph, dibit;
  assign di = cck ? ai : bi;
  assign dq = cck ? aq : bq;
  always_comb begin
    case ({di[CW-1], dq[CW-1]})
      2'b00: quad = (di >= dq) ? 2'd0 : 2'd1;
      2'b10: quad = (-di >= dq) ? 2'd2 : 2'd1;
      2'b11: quad = (di <= dq) ? 2'd2 : 2'd3;
      default: quad = (di >= -dq) ? 2'd0 : 2'd3;
    endcase
    dph = rot_rev ? 2'(prev_quad - quad) : 2'(quad - prev_quad);
    case (dph)
      2'd0: dibit = 2'b00;
      2'd1: dibit = 2'b01;
      2'd2: dibit = 2'b11;
      default: dibit = 2'b10;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rstn) prev_quad <= '0;
    else if (hdr_last || sym_stb) prev_quad <= quad;
  end
  always_ff @(posedge clk) begin
    if (!rstn || pkt_end) isi_res <= '0;
    else if (sym_stb && cck)
      isi_res <= SW'((isi_c * (ai[CW-1] ? -ci[0] : ci[0])) >>> (SW - 1));
  end

  // Symbol bits assembled first-in-time at bit 7
  logic [7:0] sym_bits, ser;
  logic [3:0] nbits, ser_cnt;
  always_comb begin
    case (rate)
      2'(dcd_pkg::DCD_R1): begin
        sym_bits = {dph[1], 7'd0};
        nbits = 4'd1;
      end
      2'(dcd_pkg::DCD_R2): begin
        sym_bits = {dibit, 6'd0};
        nbits = 4'd2;
      end
      2'(dcd_pkg::DCD_R55): begin
        sym_bits = {dibit, pi[0], pq[0], 4'd0};
        nbits = 4'd4;
      end
      default: begin
        sym_bits = {dibit, pi, pq};
        nbits = 4'd8;
      end
    endcase
  end

  // Serializer and descrambler
  logic [dcd_pkg::SCR_LEN-1:0] scr;
  logic [3:0] seed_cnt;
  logic sbit;
  assign sbit = ser[7];
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ser <= '0;
      ser_cnt <= '0;
    end else if (sym_stb) begin
      ser <= sym_bits;
      ser_cnt <= nbits;
    end else if (ser_cnt != 4'd0) begin
      ser <= {ser[6:0], 1'b0};
      ser_cnt <= ser_cnt - 4'd1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) scr <= '0;
    else if (ser_cnt != 4'd0 && !sym_stb) scr <= {scr[5:0], sbit};
  end
  always_ff @(posedge clk) begin
    if (!rstn || acq_done) seed_cnt <= '0;
    else if (sym_stb && seed_cnt != 4'(dcd_pkg::SEED_SYMS)) seed_cnt <= seed_cnt + 4'd1;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_bit <= 1'b0;
      rx_bit_valid <= 1'b0;
    end else begin
      rx_bit <= sbit ^ scr[dcd_pkg::SCR_TAP_A] ^ scr[dcd_pkg::SCR_TAP_B];
      rx_bit_valid <= ser_cnt != 4'd0 && !sym_stb
                      && seed_cnt == 4'(dcd_pkg::SEED_SYMS);
    end
  end

  // Costas error on chip transitions, lead/lag filter
  logic signed [CW-1:0] cerr;
  logic trans;
  logic signed [15:0] avg_sum, seed_frq;
  logic [3:0] avg_cnt;
  logic seeded;
  assign trans = chip_stb && (drot.i[SW-1] != ci[0][SW-1]);
  logic signed [CW-1:0] ei, eq, mag_i, mag_q;
  assign ei = CW'($signed(drot.i));
  assign eq = CW'($signed(drot.q));
  assign mag_i = ei[CW-1] ? -ei : ei;
  assign mag_q = eq[CW-1] ? -eq : eq;
  // Axis-centred four-phase error, zero on a clean decision point
  assign cerr = (mag_i >= mag_q) ? (ei[CW-1] ? -eq : eq)
                                 : (eq[CW-1] ? ei : -ei);
  always_ff @(posedge clk) begin
    if (!rstn || acq_done) begin
      avg_sum <= '0;
      avg_cnt <= '0;
      seeded <= 1'b0;
      seed_frq <= '0;
    end else if (sym_stb && !seeded) begin
      avg_sum <= avg_sum + 16'(cerr);
      avg_cnt <= avg_cnt + 4'd1;
      if (avg_cnt == 4'(dcd_pkg::AVG_SYMS - 1)) begin
        seed_frq <= 16'(((avg_sum + 16'(cerr)) * 26) >>> 8);
        seeded <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn || acq_done) begin
      nco_frq <= '0;
      nco_ph <= '0;
    end else begin
      if (sym_stb && !seeded && avg_cnt == 4'(dcd_pkg::AVG_SYMS - 1))
        nco_frq <= 16'(((avg_sum + 16'(cerr)) * 26) >>> 8);
      else if (trans && seeded)
        nco_frq <= nco_frq + 16'(cerr >>> dcd_pkg::LL_SHIFT);
      nco_ph <= nco_ph + nco_frq + ((trans && seeded) ? 16'(cerr) : 16'd0);
    end
  end

  // Symbol timing: slaved frequency accumulator or early-late, limited range
  logic [15:0] lk_acc;
  logic want_fwd, want_bwd;
  logic [SW:0] ae, al;
  assign ae = {1'b0, (early_i[SW-1] ? -early_i : early_i)}
            + {1'b0, (early_q[SW-1] ? -early_q : early_q)};
  assign al = {1'b0, (late_i[SW-1] ? -late_i : late_i)}
            + {1'b0, (late_q[SW-1] ? -late_q : late_q)};
  always_comb begin
    if (slave_on) begin
      want_fwd = lk_acc[15:14] == 2'b01;
      want_bwd = lk_acc[15:14] == 2'b10;
    end else begin
      want_fwd = sym_stb && al > ae + (SW+1)'(4);
      want_bwd = sym_stb && ae > al + (SW+1)'(4);
    end
    slip_fwd = samp_valid && want_fwd && timing_pos < 8'sd72;
    slip_bwd = samp_valid && want_bwd && timing_pos > -8'sd72;
  end
  always_ff @(posedge clk) begin
    if (!rstn || acq_done) lk_acc <= '0;
    else if (slip_fwd || slip_bwd) lk_acc <= '0;
    else if (slave_on && sym_stb) lk_acc <= lk_acc + nco_frq;
  end
  always_ff @(posedge clk) begin
    if (!rstn || acq_done) timing_pos <= '0;
    else if (slip_fwd) timing_pos <= timing_pos + 8'sd1;
    else if (slip_bwd) timing_pos <= timing_pos - 8'sd1;
  end

  // Register reads, data in the following cycle
  always_ff @(posedge clk) begin
    if (!rstn) rdata <= '0;
    else if (bus.rd) begin
      case (bus.addr)
        dcd_pkg::ROT_REG: rdata <= rot_ctrl;
        dcd_pkg::EQ_REG: rdata <= eq_ctrl;
        dcd_pkg::LCK_REG: rdata <= lck_cfg;
        dcd_pkg::TRK_REG: rdata <= trk_ctrl;
        dcd_pkg::STAT_REG: rdata <= {3'd0, slave_on, seeded, trained,
                                     seed_cnt == 4'(dcd_pkg::SEED_SYMS), cck};
        dcd_pkg::SEED_REG: rdata <= seed_frq[7:0];
        default: rdata <= '0;
      endcase
    end else rdata <= '0;
  end
endmodule : dcd_demod
`default_nettype wire

// [test/dcd_modem_model.sv]
// Behavioural modem source: Barker-spread PSK samples, two per chip
`timescale 1ns/100ps
`default_nettype none
module dcd_modem_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] step,
  output dcd_pkg::dcd_iq_t samp,
  output logic samp_valid
);
  logic [4:0] s = 5'h00;
  logic [1:0] q = 2'h0;
  logic signed [7:0] a;
  initial begin
    samp = '0;
    samp_valid = 1'b0;
  end
  // Chip on one rail only, the other rail zero; rail and sign set by the quadrant
  assign a = dcd_pkg::BARKER[4'ha - s[4:1]] ? 8'sh40 : -8'sh40;
  always @(posedge clk) begin
    if (!rstn) begin
      s <= 5'h00;
      q <= 2'h0;
      samp_valid <= 1'b0;
      samp <= '0;
    end else begin
      samp_valid <= 1'b1;
      s <= (s == 5'h15) ? 5'h00 : s + 5'h01;
      if (s == 5'h15) begin
        q <= q + step;
      end
      samp.i <= q[0] ? 8'sh00 : (q[1] ? -a : a);
      samp.q <= q[0] ? (q[1] ? -a : a) : 8'sh00;
    end
  end
endmodule : dcd_modem_model
`default_nettype wire

// [test/dcd_demod_properties.sv]
// Port checker for the receive demodulator
`timescale 1ns/100ps
`default_nettype none
module dcd_demod_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic acq_done,
  input wire dcd_pkg::dcd_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic rx_bit_valid,
  input wire logic signed [7:0] timing_pos
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rd_idle;
    !$past(bus.rd) |-> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_rot_back;
    (bus.wr && bus.addr == dcd_pkg::ROT_REG) ##1 (bus.rd && bus.addr == dcd_pkg::ROT_REG)
      |=> rdata == $past(bus.wdata, 2);
  endproperty
  a_rot_back: assert property (p_rot_back) else $error("rotation readback wrong");
  property p_eq_back;
    (bus.wr && bus.addr == dcd_pkg::EQ_REG) |=> (bus.rd && bus.addr == dcd_pkg::EQ_REG)
      |=> rdata[5:4] == $past(bus.wdata[5:4], 2);
  endproperty
  a_eq_back: assert property (p_eq_back) else $error("equalizer bits wrong");
  property p_trk_back;
    (bus.wr && bus.addr == dcd_pkg::TRK_REG) ##1 (bus.rd && bus.addr == dcd_pkg::TRK_REG)
      |=> rdata[6] == $past(bus.wdata[6], 2);
  endproperty
  a_trk_back: assert property (p_trk_back) else $error("tracking bit wrong");
  property p_unmapped;
    bus.rd && bus.addr == 8'h7f |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pos_range;
    timing_pos <= 8'sh48 && timing_pos >= -8'sh48;
  endproperty
  a_pos_range: assert property (p_pos_range) else $error("timing beyond limit");
  property p_pos_step;
    timing_pos == $past(timing_pos) || timing_pos == $past(timing_pos) + 8'sh01
      || timing_pos == $past(timing_pos) - 8'sh01;
  endproperty
  a_pos_step: assert property (p_pos_step) else $error("timing jump too big");
  property p_acq_quiet;
    acq_done |=> !rx_bit_valid [*8];
  endproperty
  a_acq_quiet: assert property (p_acq_quiet) else $error("bits right after acq");
  property p_burst;
    rx_bit_valid [*8] |=> !rx_bit_valid;
  endproperty
  a_burst: assert property (p_burst) else $error("more than 8 bits per symbol");
endmodule : dcd_demod_checker
bind dcd_demod dcd_demod_checker u_chk (.clk(clk), .rstn(rstn), .acq_done(acq_done),
  .bus(bus), .rdata(rdata), .rx_bit_valid(rx_bit_valid), .timing_pos(timing_pos));
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the receive demodulator
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  dcd_pkg::dcd_iq_t samp;
  logic samp_valid;
  logic rx_bit;
  logic rx_bit_valid;
  logic [1:0] rate = 2'h0;
  logic [1:0] step = 2'h0;
  logic acq_done = 1'b0;
  logic hdr_last = 1'b0;
  logic pkt_end = 1'b0;
  logic service_locked = 1'b0;
  logic train_valid = 1'b0;
  logic signed [7:0] train_ici = 8'sh00;
  logic signed [7:0] train_isi = 8'sh00;
  logic signed [7:0] timing_pos;
  dcd_pkg::dcd_bus_t bus = '0;
  logic [7:0] rdata;
  logic [7:0] rv;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] regs [4] = '{dcd_pkg::ROT_REG, dcd_pkg::LCK_REG, dcd_pkg::EQ_REG, dcd_pkg::TRK_REG};
  logic [7:0] vals [4] = '{8'hc0, 8'h04, 8'h30, 8'h40};
  // rate, rotation control, phase step, expected first bit of each symbol
  logic [12:0] cases [8] = '{{2'h0, 8'h00, 2'h0, 1'b0}, {2'h0, 8'h00, 2'h2, 1'b1},
    {2'h1, 8'h00, 2'h0, 1'b0}, {2'h1, 8'h00, 2'h1, 1'b1}, {2'h1, 8'h00, 2'h2, 1'b1},
    {2'h1, 8'h00, 2'h3, 1'b0}, {2'h1, 8'h80, 2'h1, 1'b0}, {2'h1, 8'h40, 2'h3, 1'b1}};
  always #5 clk = ~clk;
  dcd_modem_model u_modem (.clk(clk), .rstn(rstn), .step(step), .samp(samp),
    .samp_valid(samp_valid));
  dcd_demod u_dut (.clk(clk), .rstn(rstn), .samp(samp), .samp_valid(samp_valid), .rate(rate),
    .acq_done(acq_done), .hdr_last(hdr_last), .pkt_end(pkt_end),
    .service_locked(service_locked), .train_valid(train_valid), .train_ici(train_ici),
    .train_isi(train_isi), .bus(bus), .rdata(rdata), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .timing_pos(timing_pos));
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic run_case(input logic [12:0] c);
    int nb;
    int bl;
    int bad;
    int early;
    logic prev;
    nb = 0;
    bl = 0;
    bad = 0;
    early = 0;
    prev = 1'b0;
    wr_reg(dcd_pkg::ROT_REG, c[10:3]);
    rd_reg(dcd_pkg::ROT_REG, rv);
    @(posedge clk);
    rate <= c[12:11];
    step <= c[2:1];
    acq_done <= 1'b1;
    @(posedge clk);
    acq_done <= 1'b0;
    for (int i = 0; i < 880; i++) begin
      #1;
      if (rx_bit_valid && i < 154) early++;
      if (rx_bit_valid && !prev) begin
        nb++;
        bl = 0;
        if (nb > 10 && rx_bit !== c[0]) bad++;
      end
      if (rx_bit_valid) bl++;
      prev = rx_bit_valid;
      @(posedge clk);
    end
    `CHK(early, 0)
    `CHK(bad, 0)
    `CHK(nb > 25, 1'b1)
    `CHK(bl, (c[12:11] == 2'h0) ? 1 : 2)
    $display("Case %h done", c);
  endtask : run_case
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(dcd_pkg::STAT_REG, rv);
    `CHK(rv, 8'h00)
    foreach (regs[k]) begin
      rd_reg(regs[k], rv);
      `CHK(rv, 8'h00)
      wr_reg(regs[k], vals[k]);
      rd_reg(regs[k], rv);
      `CHK(rv, vals[k])
    end
    wr_reg(8'h7f, 8'hff);
    rd_reg(8'h7f, rv);
    `CHK(rv, 8'h00)
    // Transmitter reports locked clocks
    service_locked <= 1'b1;
    rd_reg(dcd_pkg::STAT_REG, rv);
    `CHK(rv[4], 1'b1)
    wr_reg(dcd_pkg::TRK_REG, 8'h00);
    rd_reg(dcd_pkg::STAT_REG, rv);
    `CHK(rv[4], 1'b0)
    @(posedge clk);
    train_valid <= 1'b1;
    train_ici <= 8'sh10;
    train_isi <= -8'sh08;
    @(posedge clk);
    train_valid <= 1'b0;
    rd_reg(dcd_pkg::STAT_REG, rv);
    `CHK(rv[2], 1'b1)
    @(posedge clk);
    pkt_end <= 1'b1;
    @(posedge clk);
    pkt_end <= 1'b0;
    rd_reg(dcd_pkg::STAT_REG, rv);
    `CHK(rv[2], 1'b0)
    $display("Register tests done");
    foreach (cases[k]) begin
      run_case(cases[k]);
    end
    rd_reg(dcd_pkg::STAT_REG, rv);
    `CHK(rv[3], 1'b1)
    @(posedge clk);
    rate <= 2'h3;
    hdr_last <= 1'b1;
    @(posedge clk);
    hdr_last <= 1'b0;
    rd_reg(dcd_pkg::STAT_REG, rv);
    `CHK(rv[0], 1'b1)
    $display("Demodulation tests done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
